// [inc/sss_pkg.sv]
// Package for the shadow set select block: offsets, fields, resets
package sss_pkg;

  // ------------------------------------------------------------
  // Register numbers and selects (coprocessor access)
  // ------------------------------------------------------------
  localparam logic [4:0] SSS_REG_STATUS_GRP = 5'h0C;
  localparam logic [4:0] SSS_REG_CAUSE      = 5'h0D;
  localparam logic [2:0] SSS_SEL_CTRL       = 3'h2;
  localparam logic [2:0] SSS_SEL_MAP_LOW    = 3'h3;
  localparam logic [2:0] SSS_SEL_VIEW       = 3'h4;
  localparam logic [2:0] SSS_SEL_MAP_HIGH   = 3'h5;
  localparam logic [2:0] SSS_SEL_CAUSE      = 3'h0;

  // ------------------------------------------------------------
  // Shadow set control field positions
  // ------------------------------------------------------------
  localparam int SSS_HSS_LSB  = 26;
  localparam int SSS_EXTERNAL_CTRL_SHADOW_SET_LSB = 18;
  localparam int SSS_ESS_LSB  = 12;
  localparam int SSS_PSS_LSB  = 6;
  localparam int SSS_CSS_LSB  = 0;
  localparam int SSS_SET_W    = 4;

  // ------------------------------------------------------------
  // View and cause field positions
  // ------------------------------------------------------------
  localparam int SSS_VIEW_LSB   = 2;
  localparam int SSS_MASK_W     = 10;
  localparam int SSS_PRIO_W     = 8;
  localparam int SSS_BD_BIT     = 31;
  localparam int SSS_DC_BIT     = 27;
  localparam int SSS_IV_BIT     = 23;
  localparam int SSS_WP_BIT     = 22;
  localparam int SSS_PEND_LSB   = 8;
  localparam int SSS_NUM_VEC    = 10;
  localparam int SSS_MAP_LOW_N  = 8;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0]  SSS_SET_RST   = 4'h0;
  localparam logic [31:0] SSS_MAP_RST   = 32'h0000_0000;
  localparam logic [1:0]  SSS_MASK_RST  = 2'h0;

  // ------------------------------------------------------------
  // Legal highest-set encodings
  // ------------------------------------------------------------
  localparam logic [3:0] SSS_HSS_ONE     = 4'h0;
  localparam logic [3:0] SSS_HSS_TWO     = 4'h1;
  localparam logic [3:0] SSS_HSS_FOUR    = 4'h3;
  localparam logic [3:0] SSS_HSS_EIGHT   = 4'h7;
  localparam logic [3:0] SSS_HSS_SIXTEEN = 4'hF;

  // Source of new current set on entry
  typedef enum logic [1:0] {
    SSS_SRC_EXC = 2'b00,
    SSS_SRC_MAP = 2'b01,
    SSS_SRC_EXT = 2'b10
  } sss_src_t;

endpackage : sss_pkg

// [sim/sss_eic_model.sv]
// External interrupt controller model that supplies a set per request
`timescale 1ns/1ns
module sss_eic_model
  import sss_pkg::*;
(
  // Clock and bench control
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] set_in,
  // Request toward the block
  output logic            ext_int_req,
  output logic      [3:0] ext_int_set
);
  always @(negedge clk) begin
    if (go && !ext_int_req) begin
      ext_int_req <= 1'b1;
      ext_int_set <= set_in;
    end else begin
      ext_int_req <= 1'b0;
      ext_int_set <= ~ext_int_set;
    end
  end
endmodule : sss_eic_model

// [sim/tb.sv]
// Self-checking bench for shadow set selection
`timescale 1ns/1ns
module tb
  import sss_pkg::*;
;
  logic clk = 0, rst_b = 0, cp_wr = 0, cp_rd = 0, exception_level = 0, error_level = 0;
  logic bootstrap_vectors = 0, external_ctrl_mode = 0, status_mask_wr = 0, exc_taken = 0;
  logic exc_is_interrupt = 0, exc_sets_error = 0, debug_entry = 0, exc_in_delay_slot = 0;
  logic exception_return = 0, watch_set = 0, ext_int_req, count_disable, go = 0;
  logic [4:0] cp_reg = 0, vector_spacing = 0;
  logic [2:0] cp_sel = 0;
  logic [31:0] cp_wdata = 0, cp_rdata, rd;
  logic [9:0] status_mask_wdata = 0, interrupt_mask;
  logic [3:0] vector_number = 0, ext_int_set, register_bank, set_in = 0;
  logic [5:0] hw_pending = 0;
  int err_total = 0, checked = 0, cyc = 0;

  always #25 clk = ~clk;

  sss_top #(.HIGHEST_SET(4'hF), .HAS_VINT(1'b1)) dut (.clk, .rst_b, .cp_wr, .cp_rd, .cp_reg, .cp_sel,
    .cp_wdata, .cp_rdata, .exception_level, .error_level, .bootstrap_vectors, .external_ctrl_mode,
    .vector_spacing, .status_mask_wr, .status_mask_wdata, .interrupt_mask, .exc_taken, .exc_is_interrupt,
    .exc_sets_error, .debug_entry, .exc_in_delay_slot, .exception_return, .vector_number, .ext_int_req,
    .ext_int_set, .hw_pending, .watch_set, .register_bank, .count_disable);

  sss_eic_model eic (.clk, .go, .set_in, .ext_int_req, .ext_int_set);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task cp(input logic w, input logic [4:0] r, input logic [2:0] s, input logic [31:0] d);
    @(negedge clk) {cp_wr, cp_rd, cp_reg, cp_sel, cp_wdata} = {w, !w, r, s, d};
    @(negedge clk) {cp_wr, cp_rd} = 2'b00;
    rd = cp_rdata;
  endtask : cp

  task entry(input logic i, input logic [3:0] v, input logic [3:0] e);
    @(negedge clk) {exc_taken, exc_is_interrupt, vector_number} = {1'b1, i, v};
    @(negedge clk) exc_taken = 0;
    repeat (2) @(negedge clk);
    chk("bank", {28'h0, e}, {28'h0, register_bank});
  endtask : entry

  task results;
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1;
    repeat (4) @(negedge clk);
    cp(0, 5'h0C, 3'h2, 0); chk("ctrl", 32'h3C00_0000, rd);
    cp(1, 5'h0C, 3'h2, 32'hFFFF_FFFF); cp(0, 5'h0C, 3'h2, 0); chk("ctrl", 32'h3C00_F3C0, rd);
    exc_in_delay_slot = 1;
    entry(0, 0, 4'hF);
    cp(0, 5'h0C, 3'h2, 0); chk("ctrl", 32'h3C00_F00F, rd);
    @(negedge clk) exception_return = 1;
    @(negedge clk) exception_return = 0;
    @(negedge clk) chk("bank", 0, {28'h0, register_bank});
    error_level = 1;
    entry(0, 0, 4'h0);
    error_level = 0;
    bootstrap_vectors = 1;
    entry(0, 0, 4'h0);
    bootstrap_vectors = 0;
    exc_in_delay_slot = 0;
    hw_pending = 6'h2A;
    cp(1, 5'h0D, 3'h0, 32'hFFFF_FFFF); cp(0, 5'h0D, 3'h0, 0); chk("cause", 32'h88C0_AB00, rd);
    chk("dc", 1, {31'h0, count_disable});
    cp(1, 5'h0D, 3'h0, 32'h0080_0000);
    @(negedge clk) watch_set = 1;
    @(negedge clk) watch_set = 0;
    cp(0, 5'h0D, 3'h0, 0); chk("watch", 32'h80C0_A800, rd);
    cp(1, 5'h0C, 3'h3, 32'h7654_3210);
    cp(1, 5'h0C, 3'h5, 32'hFFFF_FF98); cp(0, 5'h0C, 3'h5, 0); chk("map_high", 32'h98, rd);
    vector_spacing = 5'h01;
    for (int v = 0; v < 10; v++)
      entry(1, v[3:0], v[3:0]);
    cp(1, 5'h0C, 3'h3, 32'h3333_3333);
    entry(1, 4'h6, 4'h3);
    vector_spacing = 0;
    entry(1, 4'h5, 4'hF);
    external_ctrl_mode = 1;
    set_in = 4'h9;
    @(negedge clk) go <= 1;
    @(negedge clk) go <= 0;
    cp(0, 5'h0C, 3'h2, 0); chk("ext_set", 32'h9, {28'h0, rd[21:18]});
    entry(1, 4'h0, 4'h9);
    external_ctrl_mode = 0;
    cp(0, 5'h0C, 3'h2, 0); chk("ext_set", 0, {28'h0, rd[21:18]});
    @(negedge clk) {status_mask_wr, status_mask_wdata} = {1'b1, 10'h3FF};
    @(negedge clk) status_mask_wr = 0;
    cp(0, 5'h0C, 3'h4, 0); chk("view", 32'h3FF, rd);
    cp(1, 5'h0C, 3'h4, 32'hFFFF_F555); cp(0, 5'h0C, 3'h6, 0);
    chk("mask", 32'h155, {22'h0, interrupt_mask});
    chk("unmapped", 0, rd);
    external_ctrl_mode = 1;
    cp(0, 5'h0C, 3'h4, 0); chk("view_ext", 32'h154, rd);
    cp(1, 5'h0C, 3'h4, 32'hFFFF_FFFF);
    chk("mask_ext", 32'h3FD, {22'h0, interrupt_mask});
    results();
  end
endmodule : tb

// [src/sss_cause.sv]
// Exception cause register with writable and read-only split
`timescale 1ns/1ns
module sss_cause
  import sss_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Software write
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  // Hardware events
  input  wire logic        exc_taken,
  input  wire logic        exc_in_delay_slot,
  input  wire logic        exception_level,
  input  wire logic [5:0]  hw_pending,
  input  wire logic        watch_set,
  // Readback and controls
  output logic      [31:0] cause_value,
  output logic             vector_select,
  output logic             count_disable
);

  logic       bd_q;
  logic [1:0] sw_pend_q;
  logic       dc_q;
  logic       iv_q;
  logic       wp_q;

  // ------------------------------------------------------------
  // Branch delay flag
  // ------------------------------------------------------------
  // RQ24 delay slot record, read only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bd_q <= 1'b0;
    end else if (exc_taken && !exception_level) begin
      bd_q <= exc_in_delay_slot;
    end
  end

  // ------------------------------------------------------------
  // Writable fields
  // ------------------------------------------------------------
  // RQ22 only these fields and watch pending (below) take writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_pend_q <= 2'h0;
      dc_q      <= 1'b0;
      iv_q      <= 1'b0;
    end else if (wr_en) begin
      sw_pend_q <= wr_data[SSS_PEND_LSB +: 2];
      dc_q      <= wr_data[SSS_DC_BIT];
      iv_q      <= wr_data[SSS_IV_BIT];
    end
  end

  // Watch pending: hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= 1'b0;
    end else if (watch_set) begin
      wp_q <= 1'b1;
    end else if (wr_en) begin
      wp_q <= wr_data[SSS_WP_BIT];
    end
  end

  // RQ23 pending 7:2 carry requested priority in external mode
  always_comb begin
    cause_value                         = '0;
    cause_value[SSS_BD_BIT]             = bd_q;
    cause_value[SSS_DC_BIT]             = dc_q;
    cause_value[SSS_IV_BIT]             = iv_q;
    cause_value[SSS_WP_BIT]             = wp_q;
    cause_value[SSS_PEND_LSB+2 +: 6]    = hw_pending;
    cause_value[SSS_PEND_LSB +: 2]      = sw_pend_q;
  end

  assign vector_select = iv_q;
  assign count_disable = dc_q;

endmodule : sss_cause

// [src/sss_top.sv]
// Shadow set selection on exception entry and return
// How it works
// RQ1 - Highest set reads 15 for sixteen sets
// RQ2 - Highest set fixed at build time
// RQ3 - Software never writes sets above highest
// RQ4 - Reserved control bits read zero, ignore writes
// RQ5 - External set loaded per request, else zero
// RQ6 - Exception set field writable, resets zero
// RQ7 - Entry saves current; return restores previous
// RQ8 - No set update at error/exception/bootstrap levels
// RQ9 - Return under error or bootstrap keeps current
// RQ10 - Current set read only, resets zero
// RQ11 - Ordinary exceptions use exception set
// RQ12 - Internal vectored interrupt uses map entry
// RQ13 - External vectored interrupt uses external set
// RQ14 - Maps ignored when select or spacing zero
// RQ15 - Low map holds vectors seven to zero
// RQ16 - High map holds vectors nine, eight
// RQ17 - Map access unpredictable with one set
// RQ18 - Many vectors may share one set
// RQ19 - View shows mask outside external mode
// RQ20 - View shows packed priority in external mode
// RQ21 - View shares storage with status field
// RQ22 - Only listed cause fields are writable
// RQ23 - Pending bits mean priority in external mode
// RQ24 - Cause bit 31 records delay slot
// RQ25 - Current set drives register bank select
`timescale 1ns/1ns
module sss_top
  import sss_pkg::*;
#(
  parameter logic [3:0] HIGHEST_SET = SSS_HSS_SIXTEEN,
  parameter bit          HAS_VINT   = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Coprocessor register access
  input  wire logic        cp_wr,
  input  wire logic        cp_rd,
  input  wire logic [4:0]  cp_reg,
  input  wire logic [2:0]  cp_sel,
  input  wire logic [31:0] cp_wdata,
  output logic      [31:0] cp_rdata,
  // Processor state
  input  wire logic        exception_level,
  input  wire logic        error_level,
  input  wire logic        bootstrap_vectors,
  input  wire logic        external_ctrl_mode,
  input  wire logic [4:0]  vector_spacing,
  // Status register mask field path
  input  wire logic        status_mask_wr,
  input  wire logic [9:0]  status_mask_wdata,
  output logic      [9:0]  interrupt_mask,
  // Exception events
  input  wire logic        exc_taken,
  input  wire logic        exc_is_interrupt,
  input  wire logic        exc_sets_error,
  input  wire logic        debug_entry,
  input  wire logic        exc_in_delay_slot,
  input  wire logic        exception_return,
  input  wire logic [3:0]  vector_number,
  // External controller
  input  wire logic        ext_int_req,
  input  wire logic [3:0]  ext_int_set,
  input  wire logic [5:0]  hw_pending,
  input  wire logic        watch_set,
  // Register file bank and cause controls
  output logic      [3:0]  register_bank,
  output logic             count_disable
);

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        rst_i_b;
  logic [3:0]  ess_q;
  logic [3:0]  external_ctrl_shadow_set_q;
  logic [3:0]  pss_q;
  logic [3:0]  css_q;
  logic [9:0]  mask_q;
  logic [31:0] ctrl_value;
  logic [31:0] view_value;
  logic [31:0] map_low;
  logic [31:0] map_high;
  logic [31:0] cause_value;
  logic [3:0]  map_set;
  logic        vector_select;
  logic        wr_ctrl;
  logic        wr_view;
  logic        wr_map_lo;
  logic        wr_map_hi;
  logic        wr_cause;
  logic        entry_ok;
  logic        entry_q;
  sss_src_t    src_q;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_i_b = rst_s2_q;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [4:0] r, input logic [2:0] s,
                               input logic [4:0] rr, input logic [2:0] ss);
    hit = (r == rr) && (s == ss);
  endfunction : hit

  assign wr_ctrl   = cp_wr && hit(cp_reg, cp_sel, SSS_REG_STATUS_GRP, SSS_SEL_CTRL);
  assign wr_view   = cp_wr && hit(cp_reg, cp_sel, SSS_REG_STATUS_GRP, SSS_SEL_VIEW);
  // RQ17 map access only meaningful with shadow sets
  assign wr_map_lo = cp_wr && (HIGHEST_SET != SSS_HSS_ONE)
                     && hit(cp_reg, cp_sel, SSS_REG_STATUS_GRP, SSS_SEL_MAP_LOW);
  assign wr_map_hi = cp_wr && (HIGHEST_SET != SSS_HSS_ONE)
                     && hit(cp_reg, cp_sel, SSS_REG_STATUS_GRP, SSS_SEL_MAP_HIGH);
  assign wr_cause  = cp_wr && hit(cp_reg, cp_sel, SSS_REG_CAUSE, SSS_SEL_CAUSE);

  // RQ8 entry allowed only at normal levels
  assign entry_ok = exc_taken && !exc_sets_error && !debug_entry
                    && !exception_level && !error_level && !bootstrap_vectors;

  // ------------------------------------------------------------
  // Exception set field
  // ------------------------------------------------------------
  // RQ6 writable, resets zero
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      ess_q <= SSS_SET_RST;
    end else if (wr_ctrl) begin
      ess_q <= cp_wdata[SSS_ESS_LSB +: SSS_SET_W];
    end
  end

  // ------------------------------------------------------------
  // External controller set
  // ------------------------------------------------------------
  // RQ5 load per request in external mode
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      external_ctrl_shadow_set_q <= SSS_SET_RST;
    end else if (!external_ctrl_mode) begin
      external_ctrl_shadow_set_q <= SSS_SET_RST;
    end else if (ext_int_req) begin
      external_ctrl_shadow_set_q <= ext_int_set;
    end
  end

  // ------------------------------------------------------------
  // Source selection, captured at entry
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      src_q   <= SSS_SRC_EXC;
      entry_q <= 1'b0;
    end else begin
      entry_q <= entry_ok;
      // RQ11 RQ14 default from exception set
      src_q   <= SSS_SRC_EXC;
      if (exc_is_interrupt && vector_select) begin
        // RQ13 external controller set
        if (external_ctrl_mode) begin
          src_q <= SSS_SRC_EXT;
        // RQ12 internal vector map
        end else if (HAS_VINT && vector_spacing != 5'h00) begin
          src_q <= SSS_SRC_MAP;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Previous and current set
  // ------------------------------------------------------------
  // RQ7 save current on entry, software may write previous
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      pss_q <= SSS_SET_RST;
    end else if (entry_ok) begin
      pss_q <= css_q;
    end else if (wr_ctrl) begin
      pss_q <= cp_wdata[SSS_PSS_LSB +: SSS_SET_W];
    end
  end

  // RQ10 read only, updated by hardware only
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      css_q <= SSS_SET_RST;
    end else if (entry_q) begin
      case (src_q)
        SSS_SRC_EXC: css_q <= ess_q;
        SSS_SRC_MAP: css_q <= map_set;
        SSS_SRC_EXT: css_q <= external_ctrl_shadow_set_q;
        default:     css_q <= ess_q;
      endcase
    // RQ9 return restores only when error level and bootstrap vectors are both clear
    end else if (exception_return && !error_level && !bootstrap_vectors) begin
      css_q <= pss_q;
    end
  end

  // RQ25 bank select follows current set
  assign register_bank = css_q;

  // ------------------------------------------------------------
  // Mask and priority storage
  // ------------------------------------------------------------
  // RQ21 single storage for both paths
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      mask_q <= '0;
    end else if (wr_view) begin
      if (external_ctrl_mode) begin
        mask_q[SSS_VIEW_LSB +: SSS_PRIO_W] <= cp_wdata[SSS_VIEW_LSB +: SSS_PRIO_W];
      end else begin
        mask_q <= cp_wdata[SSS_MASK_W-1:0];
      end
    end else if (status_mask_wr) begin
      mask_q <= status_mask_wdata;
    end
  end
  assign interrupt_mask = mask_q;

  // RQ19 RQ20 view layout depends on mode
  always_comb begin
    view_value = '0;
    if (external_ctrl_mode) begin
      view_value[SSS_VIEW_LSB +: SSS_PRIO_W] = mask_q[SSS_VIEW_LSB +: SSS_PRIO_W];
    end else begin
      view_value[SSS_MASK_W-1:0] = mask_q;
    end
  end

  // ------------------------------------------------------------
  // Control register readback
  // ------------------------------------------------------------
  // RQ1 RQ2 RQ4 fixed highest set, reserved bits zero
  always_comb begin
    ctrl_value = '0;
    ctrl_value[SSS_HSS_LSB +: SSS_SET_W]   = HIGHEST_SET;
    ctrl_value[SSS_EXTERNAL_CTRL_SHADOW_SET_LSB +: SSS_SET_W] = external_ctrl_shadow_set_q;
    ctrl_value[SSS_ESS_LSB +: SSS_SET_W]   = ess_q;
    ctrl_value[SSS_PSS_LSB +: SSS_SET_W]   = pss_q;
    ctrl_value[SSS_CSS_LSB +: SSS_SET_W]   = css_q;
  end

  // Read data register
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      cp_rdata <= '0;
    end else if (cp_rd) begin
      cp_rdata <= '0;
      if (cp_reg == SSS_REG_CAUSE && cp_sel == SSS_SEL_CAUSE) begin
        cp_rdata <= cause_value;
      end else if (cp_reg == SSS_REG_STATUS_GRP) begin
        case (cp_sel)
          SSS_SEL_CTRL:     cp_rdata <= ctrl_value;
          SSS_SEL_MAP_LOW:  cp_rdata <= map_low;
          SSS_SEL_VIEW:     cp_rdata <= view_value;
          SSS_SEL_MAP_HIGH: cp_rdata <= map_high;
          default:          cp_rdata <= '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Sub-blocks
  // ------------------------------------------------------------
  sss_vec_map #(
    .NUM_VEC (SSS_NUM_VEC)
  ) u_map (
    .clk           (clk),
    .rst_b         (rst_i_b),
    .wr_low        (wr_map_lo),
    .wr_high       (wr_map_hi),
    .wr_data       (cp_wdata),
    .vector_number (vector_number),
    .lookup_set    (map_set),
    .map_low       (map_low),
    .map_high      (map_high)
  );

  sss_cause u_cause (
    .clk               (clk),
    .rst_b             (rst_i_b),
    .wr_en             (wr_cause),
    .wr_data           (cp_wdata),
    .exc_taken         (exc_taken),
    .exc_in_delay_slot (exc_in_delay_slot),
    .exception_level   (exception_level),
    .hw_pending        (hw_pending),
    .watch_set         (watch_set),
    .cause_value       (cause_value),
    .vector_select     (vector_select),
    .count_disable     (count_disable)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // RQ7 previous set takes current
  a_prev_saves_cur: assert property (@(posedge clk) disable iff (!rst_i_b)
    entry_ok |=> pss_q == $past(css_q)) else $error("previous set not saved");
  // RQ8 blocked entry keeps sets
  a_blocked_entry: assert property (@(posedge clk) disable iff (!rst_i_b)
    (exc_taken && !entry_ok && !exception_return && !entry_q && !wr_ctrl)
      |=> $stable(pss_q) && $stable(css_q)) else $error("set changed at raised level");
  // RQ9 return under error keeps current
  a_return_kept: assert property (@(posedge clk) disable iff (!rst_i_b)
    (exception_return && (error_level || bootstrap_vectors) && !entry_q)
      |=> $stable(css_q)) else $error("current changed on blocked return");
  // RQ7 return restores previous
  a_return_restore: assert property (@(posedge clk) disable iff (!rst_i_b)
    (exception_return && !error_level && !bootstrap_vectors && !entry_q)
      |=> css_q == $past(pss_q)) else $error("return did not restore");
  // RQ11 exception entry uses exception set
  a_exc_uses_ess: assert property (@(posedge clk) disable iff (!rst_i_b)
    (entry_ok && !exc_is_interrupt && !wr_ctrl) ##1 1'b1 |=> css_q == $past(ess_q, 2))
    else $error("exception entry set wrong");
  // RQ4 reserved control bits zero
  a_ctrl_reserved: assert property (@(posedge clk) disable iff (!rst_i_b)
    (ctrl_value[31:30] == 2'h0) && (ctrl_value[25:22] == 4'h0) && (ctrl_value[17:16] == 2'h0)
      && (ctrl_value[11:10] == 2'h0) && (ctrl_value[5:4] == 2'h0)) else $error("reserved bit set");
  // RQ5 external set zero outside external mode
  a_ext_set_zero: assert property (@(posedge clk) disable iff (!rst_i_b)
    !external_ctrl_mode |=> external_ctrl_shadow_set_q == 4'h0) else $error("external set not zero");
  // RQ20 view bits outside priority zero
  a_view_zero: assert property (@(posedge clk) disable iff (!rst_i_b)
    external_ctrl_mode |-> view_value[31:10] == '0 && view_value[1:0] == 2'h0)
    else $error("view stray bits");
  // RQ25 bank follows mapped set on entry
  a_bank_follows: assert property (@(posedge clk) disable iff (!rst_i_b)
    (entry_q && src_q == SSS_SRC_MAP) |=> register_bank == $past(map_set)) else $error("bank mismatch");

  c_exc_entry: cover property (@(posedge clk) disable iff (!rst_i_b) entry_ok && !exc_is_interrupt);
  c_map_entry: cover property (@(posedge clk) disable iff (!rst_i_b) entry_q && src_q == SSS_SRC_MAP);
  c_ext_entry: cover property (@(posedge clk) disable iff (!rst_i_b) entry_q && src_q == SSS_SRC_EXT);
  c_return:    cover property (@(posedge clk) disable iff (!rst_i_b) exception_return && !error_level);

endmodule : sss_top

// [src/sss_vec_map.sv]
// Per-vector shadow set map storage with registered lookup
`timescale 1ns/1ns
module sss_vec_map
  import sss_pkg::*;
#(
  parameter int NUM_VEC = SSS_NUM_VEC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Software write
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [31:0] wr_data,
  // Lookup
  input  wire logic [3:0]  vector_number,
  output logic      [3:0]  lookup_set,
  // Readback
  output logic      [31:0] map_low,
  output logic      [31:0] map_high
);

  logic [3:0] vec_set_q [NUM_VEC];

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // RQ15 RQ16 writable fields
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VEC; gi++) begin : g_vec
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          vec_set_q[gi] <= SSS_SET_RST;
        end else if (gi < SSS_MAP_LOW_N && wr_low) begin
          vec_set_q[gi] <= wr_data[(gi % SSS_MAP_LOW_N)*SSS_SET_W +: SSS_SET_W];
        end else if (gi >= SSS_MAP_LOW_N && wr_high) begin
          vec_set_q[gi] <= wr_data[(gi % SSS_MAP_LOW_N)*SSS_SET_W +: SSS_SET_W];
        end
      end
      if (gi < SSS_MAP_LOW_N) begin : g_lo
        assign map_low[gi*SSS_SET_W +: SSS_SET_W] = vec_set_q[gi];
      end else begin : g_hi
        assign map_high[(gi-SSS_MAP_LOW_N)*SSS_SET_W +: SSS_SET_W] = vec_set_q[gi];
      end
    end
  endgenerate

  // RQ16 upper bits zero
  assign map_high[31:(NUM_VEC-SSS_MAP_LOW_N)*SSS_SET_W] = '0;

  // ------------------------------------------------------------
  // Registered lookup
  // ------------------------------------------------------------
  // RQ18 many vectors may share one set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lookup_set <= SSS_SET_RST;
    end else if (int'(vector_number) < NUM_VEC) begin
      lookup_set <= vec_set_q[vector_number];
    end else begin
      lookup_set <= SSS_SET_RST;
    end
  end

endmodule : sss_vec_map
